// [lsa_top.sv]
// auto-range control and limit reporting with an ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module lsa_top #(
  parameter int P_ASSESS_CYC = lsa_pkg::ASSESS_CYC,  // assessment window length
  parameter int P_SHORT_CYC  = lsa_pkg::SHORT_CYC,   // short conversion length
  parameter int P_LONG_CYC   = lsa_pkg::LONG_CYC     // long conversion length
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ce,
  input  wire lsa_pkg::lsa_ahb_in_t  i_ahb,
  output lsa_pkg::lsa_ahb_out_t      o_ahb,
  input  wire lsa_pkg::lsa_fe_in_t   i_fe,
  input  wire logic                  i_alert_resp,
  output lsa_pkg::lsa_fe_out_t       o_fe,
  output logic                       o_int_o,
  output logic                       o_int_oe_b
);
  import lsa_pkg::*;

  // whole module state
  typedef struct packed {
    lsa_fe_in_t  fe_s1;      // first sync stage
    lsa_fe_in_t  fe_s2;      // second sync stage
    logic        fe_clk_d;   // delayed link clock for edge find
    logic        fe_ovf;     // overflow taken at a link edge
    logic [11:0] fe_mant;    // mantissa taken at a link edge
    lsa_phase_t  phase;      // measurement phase
    logic        fe_run;     // window open, toward the front end
    logic        fe_assess;  // assessment window, toward the front end
    logic [TMR_W-1:0] tmr;   // cycles left in window
    logic [3:0]  range;      // full-scale range in use
    logic [3:0]  range_select_field;        // requested range or auto
    logic        conversion_time_field;     // long window when set
    logic [1:0]  mode;       // operating mode
    logic        ovf;        // overflow flag
    logic        crf;        // conversion ready
    logic        fh;         // flag high
    logic        fl;         // flag low
    logic        latch;      // latched comparison select
    logic        interrupt_polarity_field;  // pin active high when set
    logic [1:0]  fc;         // fault count field
    logic [15:0] low_lim;    // low limit
    logic [15:0] high_lim;   // high limit
    logic [15:0] result;     // last reported result
    lsa_dir_t    fdir;       // direction being counted
    logic [3:0]  fcnt;       // consecutive fault count
    logic        int_act;    // interrupt active state
    logic        int_oe_b;   // pin enable, low while pulling
    logic        wr_pend;    // write data phase pending
    logic        wr_hit;     // write address mapped
    logic [3:0]  wr_addr;    // write byte offset
    logic        rd_pend;    // read wait cycle pending
    logic        rd_hit;     // read address mapped
    logic [3:0]  rd_addr;    // read byte offset
    logic [31:0] hrdata;     // read data
    logic        hready;     // hreadyout
  } lsa_state_t;

  // reset image of the whole state
  localparam lsa_state_t ST_RST = '{
    fe_s1: '0, fe_s2: '0, fe_clk_d: 1'b0, fe_ovf: 1'b0, fe_mant: 12'h000,
    phase: PH_IDLE, fe_run: 1'b0, fe_assess: 1'b0, tmr: '0, range: RANGE_TOP, mode: CFG_RESET[CFG_M_LSB+:2],
    range_select_field: CFG_RESET[CFG_RANGE_SEL_LSB+:4], conversion_time_field: CFG_RESET[CFG_CONV_TIME_BIT],
    ovf: CFG_RESET[CFG_OVF_BIT], crf: CFG_RESET[CFG_CRF_BIT], fh: CFG_RESET[CFG_FH_BIT], fl: CFG_RESET[CFG_FL_BIT],
    latch: CFG_RESET[CFG_L_BIT], interrupt_polarity_field: CFG_RESET[CFG_POLARITY_BIT],
    fc: CFG_RESET[CFG_FC_LSB+:2], low_lim: LOW_RESET, high_lim: HIGH_RESET,
    result: RESULT_RESET, fdir: DIR_NONE, fcnt: 4'h0, int_act: 1'b0, int_oe_b: 1'b1,
    wr_pend: 1'b0, wr_hit: 1'b0, wr_addr: 4'h0, rd_pend: 1'b0, rd_hit: 1'b0,
    rd_addr: 4'h0, hrdata: 32'h0000_0000, hready: 1'b1};

  // window lengths cut to timer width
  localparam logic [TMR_W-1:0] ASSESS_LD = TMR_W'(P_ASSESS_CYC - 1);
  localparam logic [TMR_W-1:0] SHORT_LD  = TMR_W'(P_SHORT_CYC - 1);
  localparam logic [TMR_W-1:0] LONG_LD   = TMR_W'(P_LONG_CYC - 1);

  lsa_state_t s;             // registered state
  lsa_state_t n;             // next state

  // linear light value of an exponent and mantissa word
  function automatic logic [26:0] lux_of(input logic [15:0] v);
    lux_of = {15'h0000, v[11:0]} << v[LIM_EXP_LSB+:4];
  endfunction

  // address decode shared by reads and writes
  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a[31:4] == 28'h0000000) && (a[1:0] == 2'b00);
  endfunction

  // manual range request clipped to the top setting
  function automatic logic [3:0] clip_range(input logic [3:0] r);
    clip_range = (r > RANGE_TOP) ? RANGE_TOP : r;
  endfunction

  // range chosen from an assessment taken at the top setting
  function automatic logic [3:0] assess_range(input logic [11:0] mant);
    logic [3:0]  r;
    logic [11:0] m;
    r = RANGE_TOP;
    m = mant;
    for (int k = 0; k < 11; k++) begin
      if (m < MANT_FIT_TH && r != 4'h0) begin
        m = {m[10:0], 1'b0};
        r = r - 4'h1;
      end
    end
    assess_range = r;
  endfunction

  // next range from the previous mantissa
  function automatic logic [3:0] step_range(input logic [3:0] cur, input logic [11:0] mant);
    step_range = cur;
    if (mant < MANT_VLOW_TH) begin
      step_range = (cur >= 4'h2) ? cur - 4'h2 : 4'h0;
    end else if (mant < MANT_LOW_TH) begin
      step_range = (cur != 4'h0) ? cur - 4'h1 : 4'h0;
    end else if (mant > MANT_HIGH_TH) begin
      step_range = (cur < RANGE_TOP) ? cur + 4'h1 : RANGE_TOP;
    end
  endfunction

  // consecutive fault count needed to trigger
  function automatic logic [3:0] fault_target(input logic [1:0] fc);
    fault_target = 4'h1 << fc;
  endfunction

  // next-state logic
  always_comb begin
    logic        acc;        // address phase taken
    logic        fe_rise;    // rising link clock edge
    logic        cfg_rd;     // config read side effect cycle
    logic        cfg_wr;     // config write data cycle
    logic        eoc;        // end-of-conversion reporting
    logic        done;       // conversion completed and reported
    logic        auto_rng;   // automatic ranging active
    logic        hi;         // result above high limit
    logic        lo;         // result below low limit
    logic        trig;       // fault count reached
    logic [3:0]  ncnt;       // updated fault count
    logic [15:0] wd;         // write data, low half
    logic [15:0] res;        // result being reported
    logic [31:0] rmux;       // read multiplexer
    acc      = 1'b0;
    fe_rise  = 1'b0;
    cfg_rd   = 1'b0;
    cfg_wr   = 1'b0;
    eoc      = 1'b0;
    done     = 1'b0;
    auto_rng = 1'b0;
    hi       = 1'b0;
    lo       = 1'b0;
    trig     = 1'b0;
    ncnt     = 4'h0;
    wd       = 16'h0000;
    res      = 16'h0000;
    rmux     = 32'h0000_0000;
    n        = s;

    // link synchroniser, values taken at rising link edges only
    n.fe_s1    = i_fe;
    n.fe_s2    = s.fe_s1;
    n.fe_clk_d = s.fe_s2.clk;
    fe_rise    = s.fe_s2.clk & ~s.fe_clk_d;
    if (fe_rise) begin
      n.fe_ovf  = s.fe_s2.ovf;
      n.fe_mant = s.fe_s2.mant;
    end

    // bus: writes complete without wait, reads take one wait cycle
    acc       = s.hready & i_ahb.hsel & i_ahb.htrans[1];
    n.wr_pend = acc & i_ahb.hwrite;
    n.rd_pend = acc & ~i_ahb.hwrite;
    n.hready  = ~(acc & ~i_ahb.hwrite);
    if (acc) begin
      n.wr_hit  = addr_mapped(i_ahb.haddr);
      n.rd_hit  = addr_mapped(i_ahb.haddr);
      n.wr_addr = i_ahb.haddr[3:0];
      n.rd_addr = i_ahb.haddr[3:0];
    end
    cfg_rd = s.rd_pend & s.rd_hit & (s.rd_addr == OFS_CONFIG);
    cfg_wr = s.wr_pend & s.wr_hit & (s.wr_addr == OFS_CONFIG);
    wd     = i_ahb.hwdata[15:0];

    // read data image, unmapped reads return zero
    if (s.rd_pend && s.rd_hit) begin
      case (s.rd_addr)
        OFS_RESULT: rmux = {16'h0000, s.result};
        OFS_CONFIG: rmux = {16'h0000, s.range_select_field, s.conversion_time_field, s.mode, s.ovf,
                            s.crf, s.fh, s.fl, s.latch, s.interrupt_polarity_field, 1'b0, s.fc};
        OFS_LOW:    rmux = {16'h0000, s.low_lim};
        OFS_HIGH:   rmux = {16'h0000, s.high_lim};
        default:    rmux = 32'h0000_0000;
      endcase
    end
    if (s.rd_pend) begin
      n.hrdata = rmux;
    end

    eoc      = (s.low_lim[LIM_TOP_LSB+:2] == EOC_KEY);
    auto_rng = (s.range_select_field == RANGE_SEL_AUTO);

    // config read clears ready and, when latched, the flags and pin
    if (cfg_rd) begin
      n.crf = 1'b0;
      if (s.latch) begin
        n.fh      = 1'b0;
        n.fl      = 1'b0;
        n.int_act = 1'b0;
      end else if (eoc) begin
        n.int_act = 1'b0;
      end
    end

    // alert response only acts when latched
    if (i_alert_resp && s.latch) begin
      n.int_act = 1'b0;
    end

    // limit registers
    if (s.wr_pend && s.wr_hit && s.wr_addr == OFS_LOW) begin
      n.low_lim = wd;
    end
    if (s.wr_pend && s.wr_hit && s.wr_addr == OFS_HIGH) begin
      n.high_lim = wd;
    end

    // measurement sequencer
    case (s.phase)
      PH_IDLE: n.tmr = s.tmr;  // timer holds while idle
      PH_ASSESS: begin
        if (s.tmr == '0) begin
          n.range = assess_range(s.fe_mant);
          n.phase = PH_MEASURE;
          n.tmr   = s.conversion_time_field ? LONG_LD : SHORT_LD;
        end else begin
          n.tmr = s.tmr - 1'b1;
        end
      end
      PH_MEASURE: begin
        if (auto_rng && s.fe_ovf) begin
          n.phase = PH_ASSESS;
          n.range = RANGE_TOP;
          n.tmr   = ASSESS_LD;
        end else if (s.tmr == '0) begin
          done = 1'b1;
          if (auto_rng) begin
            n.range = step_range(s.range, s.fe_mant);
          end
          if (s.mode == MODE_SINGLE) begin
            n.mode  = MODE_SHUT;
            n.phase = PH_IDLE;
          end else begin
            n.tmr = s.conversion_time_field ? LONG_LD : SHORT_LD;
          end
        end else begin
          n.tmr = s.tmr - 1'b1;
        end
      end
      default: begin
        n.phase = PH_IDLE;
      end
    endcase

    // config write: fields, ready clear and sequencer restart
    if (cfg_wr) begin
      n.range_select_field    = wd[CFG_RANGE_SEL_LSB+:4];
      n.conversion_time_field = wd[CFG_CONV_TIME_BIT];
      n.mode  = wd[CFG_M_LSB+:2];
      n.latch = wd[CFG_L_BIT];
      n.interrupt_polarity_field = wd[CFG_POLARITY_BIT];
      n.fc    = wd[CFG_FC_LSB+:2];
      if (s.latch && !wd[CFG_L_BIT]) begin
        n.int_act = 1'b0;
      end
      if (wd[CFG_M_LSB+:2] == MODE_SHUT) begin
        n.phase = PH_IDLE;
      end else begin
        n.crf = 1'b0;
        if (!s.latch && eoc) begin
          n.int_act = 1'b0;
        end
        if (wd[CFG_RANGE_SEL_LSB+:4] == RANGE_SEL_AUTO) begin
          n.phase = PH_ASSESS;
          n.range = RANGE_TOP;
          n.tmr   = ASSESS_LD;
        end else begin
          n.phase = PH_MEASURE;
          n.range = clip_range(wd[CFG_RANGE_SEL_LSB+:4]);
          n.tmr   = wd[CFG_CONV_TIME_BIT] ? LONG_LD : SHORT_LD;
        end
      end
    end

    // completion: compare, count and report, setting over any clear
    if (done) begin
      res      = {s.range, s.fe_mant};
      n.result = res;
      n.ovf    = s.fe_ovf;
      hi       = lux_of(res) > lux_of(s.high_lim);
      lo       = lux_of(res) < lux_of(s.low_lim);
      if (hi) begin
        ncnt   = (s.fdir == DIR_HIGH && s.fcnt != 4'hf) ? s.fcnt + 4'h1 : 4'h1;
        n.fdir = DIR_HIGH;
      end else if (lo) begin
        ncnt   = (s.fdir == DIR_LOW && s.fcnt != 4'hf) ? s.fcnt + 4'h1 : 4'h1;
        n.fdir = DIR_LOW;
      end else begin
        ncnt   = 4'h0;
        n.fdir = DIR_NONE;
      end
      if (hi && s.fdir == DIR_HIGH && s.fcnt == 4'hf) begin
        ncnt = 4'hf;
      end
      if (lo && s.fdir == DIR_LOW && s.fcnt == 4'hf) begin
        ncnt = 4'hf;
      end
      n.fcnt = ncnt;
      trig   = (hi | lo) && (ncnt >= fault_target(s.fc));
      n.crf  = 1'b1;
      if (eoc) begin
        n.int_act = 1'b1;
      end
      if (trig && hi) begin
        n.fh = 1'b1;
        if (!s.latch) begin
          n.fl = 1'b0;
        end
        if (!eoc) begin
          n.int_act = 1'b1;
        end
      end
      if (trig && lo) begin
        n.fl = 1'b1;
        if (!s.latch) begin
          n.fh = 1'b0;
        end
        if (!eoc) begin
          n.int_act = s.latch;
        end
      end
    end

    // open-drain pin: pull low when active xor polarity
    n.int_oe_b  = ~(n.int_act ^ n.interrupt_polarity_field);
    n.fe_run    = (n.phase != PH_IDLE);    // registered so the pin toward the front end is glitch free
    n.fe_assess = (n.phase == PH_ASSESS);  // registered copy of the assessment phase
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= ST_RST;
    end else if (i_ce) begin
      s <= n;
    end
  end

  // outputs straight from state, with hresp and pin data tied low
  assign o_ahb.hrdata    = s.hrdata;
  assign o_ahb.hreadyout = s.hready;
  assign o_ahb.hresp     = 1'b0;
  assign o_fe.range      = s.range;
  assign o_fe.run        = s.fe_run;
  assign o_fe.assess     = s.fe_assess;
  assign o_int_o         = 1'b0;
  assign o_int_oe_b      = s.int_oe_b;

endmodule // lsa_top

// [lsa_pkg.sv]
// constants, field layouts and carrier types for the light sensor auto-range and alert block
// Operation
// - range field 1100b selects automatic ranging
// - auto entry: 10 ms assessment, then pick range
// - next range from last result, down 1-2/up 1
// - overflow aborts, reassesses 10 ms, restarts measurement
// - config bit 4 picks latched or transparent
// - low-limit top bits 11b select end-of-conversion
// - fault when result above high or below low
// - trigger after fault-count consecutive same-direction faults
// - latched trigger sets its flag, interrupt, ready
// - latched state held until config read clears
// - latched alert response drops interrupt only
// - completion without trigger sets conversion ready, plus the interrupt under end-of-conversion
// - shutdown write keeps state; active write clears ready
// - transparent high: interrupt on, high 1, low 0
// - transparent low: interrupt off, low 1, high 0
// - transparent flags ignore config reads and writes
// - transparent mode ignores alert response entirely
// - pin low when active xor polarity set
// - config read clears conversion ready right after
// - end-of-conversion asserts interrupt every completion
// - interrupt pin is open-drain, released otherwise
package lsa_pkg;

  // timing base
  localparam int CLK_KHZ     = 250000;               // core clock in kHz
  localparam int T_ASSESS_MS = 10;                   // range assessment time
  localparam int T_SHORT_MS  = 100;                  // short conversion time
  localparam int T_LONG_MS   = 800;                  // long conversion time
  localparam int ASSESS_CYC  = T_ASSESS_MS * CLK_KHZ;
  localparam int SHORT_CYC   = T_SHORT_MS * CLK_KHZ;
  localparam int LONG_CYC    = T_LONG_MS * CLK_KHZ;
  localparam int TMR_W       = 28;                   // holds the longest count

  // register byte offsets
  localparam logic [3:0] OFS_RESULT = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  localparam logic [3:0] OFS_LOW    = 4'h8;
  localparam logic [3:0] OFS_HIGH   = 4'hc;

  // configuration field positions
  localparam int CFG_RANGE_SEL_LSB = 12;             // range_select_field
  localparam int CFG_CONV_TIME_BIT = 11;             // conversion_time_field
  localparam int CFG_M_LSB         = 9;
  localparam int CFG_OVF_BIT       = 8;
  localparam int CFG_CRF_BIT       = 7;
  localparam int CFG_FH_BIT        = 6;
  localparam int CFG_FL_BIT        = 5;
  localparam int CFG_L_BIT         = 4;
  localparam int CFG_POLARITY_BIT  = 3;              // interrupt_polarity_field
  localparam int CFG_FC_LSB        = 0;
  localparam int LIM_EXP_LSB       = 12;             // exponent of result and limits
  localparam int LIM_TOP_LSB       = 14;             // low_limit_top_bits position

  // reset values
  localparam logic [15:0] CFG_RESET    = 16'hc810;
  localparam logic [15:0] LOW_RESET    = 16'h0000;
  localparam logic [15:0] HIGH_RESET   = 16'hbfff;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // codes
  localparam logic [3:0] RANGE_SEL_AUTO = 4'hc;      // automatic range request
  localparam logic [3:0] RANGE_TOP      = 4'hb;      // highest full-scale setting
  localparam logic [1:0] MODE_SHUT   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] EOC_KEY     = 2'h3;

  // range stepping thresholds on the 12-bit mantissa
  localparam logic [11:0] MANT_VLOW_TH = 12'h100;    // step down by two below this
  localparam logic [11:0] MANT_LOW_TH  = 12'h400;    // step down by one below this
  localparam logic [11:0] MANT_HIGH_TH = 12'hc00;    // step up by one above this
  localparam logic [11:0] MANT_FIT_TH  = 12'h600;    // assessment doubling limit

  typedef enum logic [1:0] {PH_IDLE, PH_ASSESS, PH_MEASURE} lsa_phase_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_HIGH, DIR_LOW} lsa_dir_t;

  // ahb-lite slave inputs
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } lsa_ahb_in_t;

  // ahb-lite slave outputs
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } lsa_ahb_out_t;

  // front-end result link, sampled on its own clock edges
  typedef struct packed {
    logic        clk;
    logic        ovf;
    logic [11:0] mant;
  } lsa_fe_in_t;

  // controls toward the front end
  typedef struct packed {
    logic [3:0] range;
    logic       run;
    logic       assess;
  } lsa_fe_out_t;

endpackage

// [lsa_fe_model.sv]
// behavioural front end that feeds results over the sampled link clock
`timescale 1ns/1ps
module lsa_fe_model (
  input  wire logic          i_run,   // a conversion window is open
  input  wire logic [11:0]   i_mant,  // mantissa to present in the next frame
  input  wire logic          i_ovf,   // overflow to present in the next frame
  output lsa_pkg::lsa_fe_in_t o_fe    // link toward the block
);
  import lsa_pkg::*;

  // link clock runs only while a window is open and stands low otherwise
  // data change on the falling half so they are steady around every rising edge
  // one process owns the link so it has a single driver
  initial begin
    o_fe = '0;
    forever begin
      wait (i_run === 1'b1);
      o_fe.mant = i_mant;
      o_fe.ovf  = i_ovf;
      #62.5 o_fe.clk = 1'b1;
      #62.5 o_fe.clk = 1'b0;
    end
  end
endmodule // lsa_fe_model

// [lsa_top_asserts.sv]
// concurrent checks on the ports of the auto-range and alert block
`timescale 1ns/1ps
module lsa_top_asserts #(
  parameter int P_ASSESS_CYC = 20  // assessment window length
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst_b,
  input wire logic                  i_ce,
  input wire lsa_pkg::lsa_ahb_in_t  i_ahb,
  input wire lsa_pkg::lsa_ahb_out_t o_ahb,
  input wire lsa_pkg::lsa_fe_in_t   i_fe,
  input wire logic                  i_alert_resp,
  input wire lsa_pkg::lsa_fe_out_t  o_fe,
  input wire logic                  o_int_o,
  input wire logic                  o_int_oe_b
);
  import lsa_pkg::*;

  logic [31:0] asc_cnt_reg;  // cycles spent in the current assessment
  logic        take_rd;      // a read address phase is accepted
  logic        take_wr;      // a write address phase is accepted

  assign take_rd = i_ce && i_ahb.hsel && i_ahb.htrans[1] && !i_ahb.hwrite && o_ahb.hreadyout;
  assign take_wr = i_ce && i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hwrite && o_ahb.hreadyout;

  // count assessment cycles, cleared whenever the window is closed
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      asc_cnt_reg <= '0;
    end else begin
      asc_cnt_reg <= o_fe.assess ? asc_cnt_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_resp_okay: assert property (o_ahb.hresp == 1'b0) else $error("bus response not okay");
  a_read_wait: assert property (take_rd |=> !o_ahb.hreadyout ##1 o_ahb.hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take_wr |=> o_ahb.hreadyout) else $error("write stalled");
  a_rdata_hold: assert property (o_ahb.hreadyout && $past(o_ahb.hreadyout) |-> $stable(o_ahb.hrdata))
    else $error("read data moved without a read");
  a_pin_open_drain: assert property (o_int_o == 1'b0) else $error("pin data not low");
  a_assess_runs: assert property (o_fe.assess |-> o_fe.run && o_fe.range == RANGE_TOP)
    else $error("assessment not at top range");
  a_assess_len: assert property (o_fe.assess |-> asc_cnt_reg < P_ASSESS_CYC)
    else $error("assessment too long");
  a_range_top: assert property (o_fe.range <= RANGE_TOP) else $error("range past top");
  a_range_up: assert property (!o_fe.assess && !$past(o_fe.assess) && o_fe.range > $past(o_fe.range)
    |-> o_fe.range == $past(o_fe.range) + 4'h1) else $error("range rose by more than one");
  a_range_down: assert property (!o_fe.assess && !$past(o_fe.assess)
    |-> o_fe.range + 4'h2 >= $past(o_fe.range)) else $error("range fell by more than two");
endmodule // lsa_top_asserts

bind lsa_top lsa_top_asserts #(.P_ASSESS_CYC(P_ASSESS_CYC)) lsa_top_asserts_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_ahb(i_ahb), .o_ahb(o_ahb), .i_fe(i_fe),
  .i_alert_resp(i_alert_resp), .o_fe(o_fe), .o_int_o(o_int_o), .o_int_oe_b(o_int_oe_b));

// [tb_top.sv]
// register-level testbench for the auto-range and alert block
`timescale 1ns/1ps
module tb_top;
  import lsa_pkg::*;
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

  logic         i_clk    = 1'b0;   // core clock
  logic         i_rst_b  = 1'b0;   // reset, active low
  logic         alert    = 1'b0;   // alert response pulse
  lsa_ahb_in_t  ahb      = '0;     // bus master outputs
  lsa_ahb_out_t ahb_o;             // slave answer
  lsa_fe_in_t   fe;                // link from the front end
  lsa_fe_out_t  fe_o;              // controls to the front end
  logic         int_o;             // pin data
  logic         int_oe_b;          // pin enable, low pulls low
  logic [11:0]  mant     = 12'h800;  // light level given to the front end
  logic         ovf      = 1'b0;   // overflow given to the front end
  int           n_fail   = 0;
  int           checks_done = 0;

  always #2 i_clk = ~i_clk;

  lsa_top #(.P_ASSESS_CYC(20), .P_SHORT_CYC(100), .P_LONG_CYC(200)) lsa_top_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_ahb(ahb), .o_ahb(ahb_o), .i_fe(fe),
    .i_alert_resp(alert), .o_fe(fe_o), .o_int_o(int_o), .o_int_oe_b(int_oe_b));

  lsa_fe_model lsa_fe_model_inst (.i_run(fe_o.run), .i_mant(mant), .i_ovf(ovf), .o_fe(fe));

  // print the counts and the verdict, then stop
  task end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one single transfer: address phase until ready, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    ahb.hsel   <= 1'b1;
    ahb.htrans <= 2'h2;
    ahb.hwrite <= w;
    ahb.haddr  <= {24'h0, a};
    ahb.hsize  <= 3'h2;
    do begin @(posedge i_clk); n++; end while (ahb_o.hreadyout !== 1'b1 && n < 50);
    ahb.hsel   <= 1'b0;
    ahb.htrans <= 2'h0;
    ahb.hwdata <= {16'h0, d};
    do begin @(posedge i_clk); n++; end while (ahb_o.hreadyout !== 1'b1 && n < 50);
    r = ahb_o.hrdata;
    if (n >= 50) begin n_fail++; end_of_test(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, a, 16'h0, r);
    `CHK(r, {16'h0, e})
  endtask

  // wait for the pin enable to reach a level, bounded
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_oe_b !== lvl && n < 3000) begin @(posedge i_clk); n++; end
    `CHK(int_oe_b, lvl)
    if (n >= 3000) end_of_test();
  endtask

  // one-cycle alert response, then let the pin settle
  task automatic pulse_alert;
    alert <= 1'b1;
    @(posedge i_clk);
    alert <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(8'h04, 16'hc810);
    rd(8'h08, 16'h0000);
    rd(8'h0c, 16'hbfff);
    rd(8'h10, 16'h0000);
    // latched high fault in single auto-range mode
    wr(8'h0c, 16'h0010);
    wr(8'h04, 16'hc210);
    wait_int(1'b0);
    rd(8'h00, 16'hb800);
    rd(8'h04, 16'hc0d0);
    `CHK(int_oe_b, 1'b1)
    rd(8'h04, 16'hc010);
    // alert response drops the pin only
    wr(8'h04, 16'hc210);
    wait_int(1'b0);
    pulse_alert();
    `CHK(int_oe_b, 1'b1)
    rd(8'h04, 16'hc0d0);
    // transparent high fault ignores reads and alert
    wr(8'h04, 16'hc200);
    wait_int(1'b0);
    rd(8'h04, 16'hc0c0);
    `CHK(int_oe_b, 1'b0)
    pulse_alert();
    `CHK(int_oe_b, 1'b0)
    // transparent low fault, then polarity flip by a shutdown write
    mant <= 12'h000;
    wr(8'h0c, 16'h0200);
    wr(8'h08, 16'h0100);
    wr(8'h04, 16'hc200);
    wait_int(1'b1);
    rd(8'h00, 16'h0000);
    wr(8'h04, 16'hc008);
    repeat (2) @(posedge i_clk);
    `CHK(int_oe_b, 1'b0)
    rd(8'h04, 16'hc0a8);
    // end-of-conversion reporting in latched mode
    mant <= 12'h800;
    wr(8'h04, 16'hc010);
    rd(8'h04, 16'hc030);
    wr(8'h0c, 16'hbfff);
    wr(8'h08, 16'hc000);
    wr(8'h04, 16'hc210);
    wait_int(1'b0);
    rd(8'h04, 16'hc090);
    `CHK(int_oe_b, 1'b1)
    // overflow keeps aborting: no result, no ready, no pin, then a clean result
    mant <= 12'h123;
    ovf  <= 1'b1;
    wr(8'h04, 16'hc210);
    repeat (300) @(posedge i_clk);
    rd(8'h04, 16'hc210);
    rd(8'h00, 16'hb800);
    `CHK(int_oe_b, 1'b1)
    ovf <= 1'b0;
    wait_int(1'b0);
    rd(8'h00, 16'h8123);
    rd(8'h04, 16'hc090);
    // fault count of two: first high fault counts, second triggers
    wr(8'h08, 16'h0000);
    wr(8'h0c, 16'h0010);
    wr(8'h04, 16'hc411);
    repeat (170) @(posedge i_clk);
    `CHK(int_oe_b, 1'b1)
    rd(8'h04, 16'hc491);
    wait_int(1'b0);
    rd(8'h04, 16'hc4d1);
    end_of_test();
  end
endmodule // tb_top
